// *** dxr_regs.sv ***
`timescale 1ns/10ps
module dxr_regs (
    input wire logic clk,
    input wire logic nrst,
    input wire dxr_pkg::dxr_host_t host,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    output logic [15:0] frame_y_offset,
    input wire logic [7:0] h_char_count,
    input wire logic odd_frame,
    output logic interlace_enabled,
    output logic vtiming_advance,
    output dxr_pkg::dxr_dram_t dram,
    output logic [7:0] dram_arbitration_0,
    output logic [7:0] dram_arbitration_1,
    input wire logic [1:0] ddc_in,
    output logic [1:0] ddc_out,
    output logic [1:0] ddc_oe,
    output dxr_pkg::dxr_tv_t tv,
    input wire logic vip_bt_dir,
    input wire logic vip_hs_dir,
    input wire logic tvo_bt,
    input wire logic tvo_hs,
    input wire logic vip_bt,
    input wire logic vip_hs,
    input wire logic bt_in,
    input wire logic hs_in,
    output logic bt_out,
    output logic bt_oe,
    output logic hs_out,
    output logic hs_oe,
    output logic bt_level,
    output logic hs_level
);
    import dxr_pkg::*;

    logic [7:0] index; // Selected register
    logic [7:0] frame_y_offset_low;
    logic [7:0] frame_y_offset_high;
    logic [7:0] interlace_half_field_start;
    logic [7:0] dram_timing_parameters;
    logic [7:0] dram_arbitration_ctrl_0;
    logic [7:0] dram_arbitration_ctrl_1;
    logic [7:0] monitor_data_channel_ctrl;
    logic [7:0] tv_interface_ctrl;
    logic [1:0] ddc_s1; // Synchroniser first stage
    logic [1:0] ddc_s2;
    logic [1:0] ddc_s3;
    logic [1:0] ddc_level; // Filtered pin levels
    logic [2:0] bt_s;
    logic [2:0] hs_s;
    logic data_wr; // Write through data port
    logic data_rd;
    logic [7:0] next_rdata;
    logic [1:0] next_bt_dir;
    logic [1:0] next_hs_dir;

    // Register read mux, used by the data port read path only
    function automatic logic [7:0] read_reg(input logic [7:0] idx);
        logic [7:0] r;
        r = RST_ZERO;
        if (idx == IDX_FRAME_Y_OFFSET_LOW) begin
            r = frame_y_offset_low;
        end else if (idx == IDX_FRAME_Y_OFFSET_HIGH) begin
            r = frame_y_offset_high;
        end else if (idx == IDX_INTERLACE_HALF_FIELD_START) begin
            r = interlace_half_field_start;
        end else if (idx == IDX_IMPLEMENTATION_NUMBER) begin
            r = IMPL_NUMBER;
        end else if (idx == IDX_GRAPHICS_VERSION_NUMBER) begin
            r = VERSION_NUMBER;
        end else if (idx == IDX_DRAM_TIMING_PARAMETERS) begin
            r = dram_timing_parameters;
        end else if (idx == IDX_DRAM_ARBITRATION_CTRL_0) begin
            r = dram_arbitration_ctrl_0;
        end else if (idx == IDX_DRAM_ARBITRATION_CTRL_1) begin
            r = dram_arbitration_ctrl_1;
        end else if (idx == IDX_MONITOR_DATA_CHANNEL_CTRL) begin
            // Written bits, live levels, reserved bits as stored
            r = {monitor_data_channel_ctrl[DW_HI:DW_LO], ddc_level,
                 monitor_data_channel_ctrl[DX_HI:0]};
        end else if (idx == IDX_TV_INTERFACE_CTRL) begin
            r = tv_interface_ctrl;
        end
        return r;
    endfunction

    assign data_wr = host.wr && host.sel_data;
    assign data_rd = host.rd && host.sel_data;

    // Index port; data port uses it unchanged
    always_ff @(posedge clk) begin
        if (!nrst) begin
            index <= RST_ZERO;
        end else if (host.wr && !host.sel_data) begin
            index <= host.wdata;
        end
    end

    // Read answer, one cycle after the strobe
    always_comb begin
        next_rdata = host.sel_data ? read_reg(index) : index;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            host_rdata <= RST_ZERO;
            host_rvalid <= 1'b0;
        end else begin
            host_rvalid <= host.rd;
            if (host.rd) begin
                host_rdata <= next_rdata;
            end
        end
    end

    // Frame offset bytes; undefined at reset, cleared here
    always_ff @(posedge clk) begin
        if (!nrst) begin
            frame_y_offset_low <= RST_ZERO;
            frame_y_offset_high <= RST_ZERO;
        end else if (data_wr) begin
            if (index == IDX_FRAME_Y_OFFSET_LOW) begin
                frame_y_offset_low <= host.wdata;
            end else if (index == IDX_FRAME_Y_OFFSET_HIGH) begin
                frame_y_offset_high <= host.wdata;
            end
        end
    end

    // Signed offset; high byte on top
    always_ff @(posedge clk) begin
        if (!nrst) begin
            frame_y_offset <= {RST_ZERO, RST_ZERO};
        end else begin
            frame_y_offset <= {frame_y_offset_high, frame_y_offset_low};
        end
    end

    // Half-field start; all ones means no interlace
    always_ff @(posedge clk) begin
        if (!nrst) begin
            interlace_half_field_start <= RST_HALF_FIELD;
        end else if (data_wr && index == IDX_INTERLACE_HALF_FIELD_START) begin
            interlace_half_field_start <= host.wdata;
        end
    end

    // Vertical advance on odd frames at the match point
    always_ff @(posedge clk) begin
        if (!nrst) begin
            interlace_enabled <= 1'b0;
            vtiming_advance <= 1'b0;
        end else begin
            interlace_enabled <= interlace_half_field_start != INTERLACE_OFF;
            // Software is expected to set about half the total
            vtiming_advance <= odd_frame
                && interlace_half_field_start != INTERLACE_OFF
                && h_char_count == interlace_half_field_start;
        end
    end

    // Timing register and reserved arbitration bytes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dram_timing_parameters <= RST_ZERO;
            dram_arbitration_ctrl_0 <= RST_ZERO;
            dram_arbitration_ctrl_1 <= RST_ZERO;
        end else if (data_wr) begin
            if (index == IDX_DRAM_TIMING_PARAMETERS) begin
                dram_timing_parameters <= host.wdata;
            end else if (index == IDX_DRAM_ARBITRATION_CTRL_0) begin
                // Stored as written; nonzero is a software fault
                dram_arbitration_ctrl_0 <= host.wdata;
            end else if (index == IDX_DRAM_ARBITRATION_CTRL_1) begin
                dram_arbitration_ctrl_1 <= host.wdata;
            end
        end
    end

    // Decoded memory timing for the sequencer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dram <= '0;
            dram_arbitration_0 <= RST_ZERO;
            dram_arbitration_1 <= RST_ZERO;
        end else begin
            dram_arbitration_0 <= dram_arbitration_ctrl_0;
            dram_arbitration_1 <= dram_arbitration_ctrl_1;
            dram.mem_type <= dram_timing_parameters[MT_HI:MT_LO];
            dram.cas_to_ras_half <= HC_CAS_TO_RAS;
            // Undefined templates fall back to the faster one
            if (dram_timing_parameters[TP_HI:TP_LO] == TPL_SLOW) begin
                dram.precharge_half <= HC_SLOW_PRECHARGE;
                dram.ras_to_cas_half <= HC_SLOW_RAS_TO_CAS;
            end else begin
                dram.precharge_half <= HC_STD_PRECHARGE;
                dram.ras_to_cas_half <= HC_STD_RAS_TO_CAS;
            end
            // Pulse width only matters for fast page parts
            if (dram_timing_parameters[MT_HI:MT_LO] == MEM_FPM
                && dram_timing_parameters[CAS_BIT]) begin
                dram.cas_pulse_quarter <= QC_CAS_LONG;
            end else begin
                dram.cas_pulse_quarter <= QC_CAS_SHORT;
            end
            // Gap only used with extended data out
            if (dram_timing_parameters[MT_HI:MT_LO] != MEM_EDO) begin
                dram.rd_wr_gap_clks <= CK_GAP_NONE;
            end else if (dram_timing_parameters[GAP_BIT]) begin
                dram.rd_wr_gap_clks <= CK_GAP_LONG;
            end else begin
                dram.rd_wr_gap_clks <= CK_GAP_SHORT;
            end
            dram.row_strobe_release <= dram_timing_parameters[RSR_BIT];
        end
    end

    // Data-channel control; sampled bits are stored but not read back
    always_ff @(posedge clk) begin
        if (!nrst) begin
            monitor_data_channel_ctrl <= RST_DATA_CHANNEL;
        end else if (data_wr && index == IDX_MONITOR_DATA_CHANNEL_CTRL) begin
            monitor_data_channel_ctrl <= host.wdata;
        end
    end

    // Open drain: a one lets the pull-up win
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ddc_out <= 2'h0;
            ddc_oe <= 2'h0;
        end else begin
            ddc_out <= 2'h0;
            ddc_oe <= ~monitor_data_channel_ctrl[DW_HI:DW_LO];
        end
    end

    // Three-stage sampling of the data-channel pins
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ddc_s1 <= 2'h3;
            ddc_s2 <= 2'h3;
            ddc_s3 <= 2'h3;
            ddc_level <= 2'h3;
        end else begin
            ddc_s1 <= ddc_in;
            ddc_s2 <= ddc_s1;
            ddc_s3 <= ddc_s2;
            // A level counts once two stages agree
            for (int i = 0; i < 2; i++) begin
                if (ddc_s2[i] == ddc_s3[i]) begin
                    ddc_level[i] <= ddc_s3[i];
                end
            end
        end
    end

    // TV interface control register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tv_interface_ctrl <= RST_ZERO;
        end else if (data_wr && index == IDX_TV_INTERFACE_CTRL) begin
            tv_interface_ctrl <= host.wdata;
        end
    end

    // TV controls towards encoder and filter
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tv <= '0;
        end else begin
            tv.enable <= tv_interface_ctrl[TV_EN_BIT];
            tv.ccir656 <= tv_interface_ctrl[TV_656_BIT];
            tv.graphics_sel <= tv_interface_ctrl[TV_GFX_BIT];
            tv.filter_kernel <= tv_interface_ctrl[FF_HI:0];
            // Luma-only has no meaning with filter off
            tv.luma_only <= tv_interface_ctrl[FF_LUMA_BIT]
                && tv_interface_ctrl[FF_HI:0] != 2'h0;
        end
    end

    // Pin direction: bit 0 enable, bit 1 from TV generator
    always_comb begin
        next_bt_dir = {tv_interface_ctrl[TV_BT_BIT],
                       tv_interface_ctrl[TV_BT_BIT] || vip_bt_dir};
        next_hs_dir = {tv_interface_ctrl[TV_HS_BIT],
                       tv_interface_ctrl[TV_HS_BIT] || vip_hs_dir};
    end

    // Field and sync pins driven from the chosen generator
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bt_out <= 1'b0;
            bt_oe <= 1'b0;
            hs_out <= 1'b0;
            hs_oe <= 1'b0;
        end else begin
            bt_oe <= next_bt_dir[0];
            bt_out <= next_bt_dir[1] ? tvo_bt : vip_bt;
            hs_oe <= next_hs_dir[0];
            hs_out <= next_hs_dir[1] ? tvo_hs : vip_hs;
        end
    end

    // Sampled field and sync levels when used as inputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bt_s <= 3'h0;
            hs_s <= 3'h0;
            bt_level <= 1'b0;
            hs_level <= 1'b0;
        end else begin
            bt_s <= {bt_s[1:0], bt_in};
            hs_s <= {hs_s[1:0], hs_in};
            if (bt_s[1] == bt_s[2]) begin
                bt_level <= bt_s[2];
            end
            if (hs_s[1] == hs_s[2]) begin
                hs_level <= hs_s[2];
            end
        end
    end

    // Checks
    sequence s_write_ddc;
        data_wr && index == IDX_MONITOR_DATA_CHANNEL_CTRL;
    endsequence

    a_offset_pair: assert property (@(posedge clk) disable iff (!nrst)
        ##1 frame_y_offset == {$past(frame_y_offset_high), $past(frame_y_offset_low)})
        else $error("frame offset does not follow its two bytes");

    a_half_field_match: assert property (@(posedge clk) disable iff (!nrst)
        odd_frame && h_char_count == interlace_half_field_start
        && interlace_half_field_start != INTERLACE_OFF |=> vtiming_advance)
        else $error("no vertical advance at half-field match");

    a_interlace_off: assert property (@(posedge clk) disable iff (!nrst)
        interlace_half_field_start == INTERLACE_OFF |=> !vtiming_advance && !interlace_enabled)
        else $error("interlace acted while disabled");

    a_ident_read: assert property (@(posedge clk) disable iff (!nrst)
        data_rd && index == IDX_IMPLEMENTATION_NUMBER |=> host_rdata == IMPL_NUMBER)
        else $error("implementation number read wrong");

    a_mem_type: assert property (@(posedge clk) disable iff (!nrst)
        ##1 dram.mem_type == $past(dram_timing_parameters[MT_HI:MT_LO]))
        else $error("memory type not decoded");

    a_slow_template: assert property (@(posedge clk) disable iff (!nrst)
        dram_timing_parameters[TP_HI:TP_LO] == TPL_SLOW
        |=> dram.precharge_half == HC_SLOW_PRECHARGE && dram.ras_to_cas_half == HC_SLOW_RAS_TO_CAS)
        else $error("slow template not applied");

    a_cas_width: assert property (@(posedge clk) disable iff (!nrst)
        dram_timing_parameters[MT_HI:MT_LO] == MEM_FPM && dram_timing_parameters[CAS_BIT]
        |=> dram.cas_pulse_quarter == QC_CAS_LONG)
        else $error("long column pulse not applied");

    a_edo_gap: assert property (@(posedge clk) disable iff (!nrst)
        dram_timing_parameters[MT_HI:MT_LO] == MEM_EDO && !dram_timing_parameters[GAP_BIT]
        |=> dram.rd_wr_gap_clks == CK_GAP_SHORT)
        else $error("short read-write gap not applied");

    a_ddc_drive: assert property (@(posedge clk) disable iff (!nrst)
        s_write_ddc |=> ##1 ddc_oe == ~$past(host.wdata[DW_HI:DW_LO], 2) && ddc_out == 2'h0)
        else $error("data-channel drive does not follow write");

    a_ddc_readback: assert property (@(posedge clk) disable iff (!nrst)
        data_rd && index == IDX_MONITOR_DATA_CHANNEL_CTRL
        |=> host_rdata[DW_HI:DW_LO] == $past(monitor_data_channel_ctrl[DW_HI:DW_LO])
        && host_rdata[DR_HI:DR_LO] == $past(ddc_level))
        else $error("data-channel readback wrong");

    a_tv_enable: assert property (@(posedge clk) disable iff (!nrst)
        ##1 tv.enable == $past(tv_interface_ctrl[TV_EN_BIT]))
        else $error("TV enable does not follow control");

    a_bt_dir: assert property (@(posedge clk) disable iff (!nrst)
        !tv_interface_ctrl[TV_BT_BIT] && !vip_bt_dir |=> !bt_oe)
        else $error("field pin driven while input");

    a_hs_tvo: assert property (@(posedge clk) disable iff (!nrst)
        tv_interface_ctrl[TV_HS_BIT] |=> hs_oe && hs_out == $past(tvo_hs))
        else $error("sync pin not driven by TV generator");
endmodule

// *** dxr_pkg.sv ***
// What this block does
// - Two bytes form signed 16-bit frame offset
// - Odd frames advance vertical timing on match
// - All-ones half-field start disables interlace; reset
// - Two read-only identification bytes
// - Timing bits 7-6 select memory type
// - Bits 5-3 pick row/column timing template
// - Bit 2 sets FPM column pulse width
// - Bit 1 sets EDO read-write hit gap
// - Bit 0 releases row strobe; resets zero
// - Bits 7-6 drive open-drain data-channel pins
// - Write bits read back last written value
// - Bits 5-4 return sampled pin levels
// - Data-channel register resets all ones
// - TV interface enabled by bit 7
// - Bit 6 inserts timing reference codes
// - Bit 5 selects graphics or video input
// - Field pin direction from bit 4, bit 29
// - Sync pin direction from bit 3, bit 28
// - Bits 2-0 select anti-flicker filter
package dxr_pkg;
    // Register indexes behind the data port
    localparam logic [7:0] IDX_FRAME_Y_OFFSET_LOW = 8'h34;
    localparam logic [7:0] IDX_FRAME_Y_OFFSET_HIGH = 8'h35;
    localparam logic [7:0] IDX_INTERLACE_HALF_FIELD_START = 8'h39;
    localparam logic [7:0] IDX_IMPLEMENTATION_NUMBER = 8'h3a;
    localparam logic [7:0] IDX_GRAPHICS_VERSION_NUMBER = 8'h3b;
    localparam logic [7:0] IDX_DRAM_TIMING_PARAMETERS = 8'h3c;
    localparam logic [7:0] IDX_DRAM_ARBITRATION_CTRL_0 = 8'h3d;
    localparam logic [7:0] IDX_DRAM_ARBITRATION_CTRL_1 = 8'h3e;
    localparam logic [7:0] IDX_MONITOR_DATA_CHANNEL_CTRL = 8'h3f;
    localparam logic [7:0] IDX_TV_INTERFACE_CTRL = 8'h40;
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_HALF_FIELD = 8'hff;
    localparam logic [7:0] RST_DATA_CHANNEL = 8'hff;
    localparam logic [7:0] INTERLACE_OFF = 8'hff;
    // Identification values, arbitrary
    localparam logic [7:0] IMPL_NUMBER = 8'h5a;
    localparam logic [7:0] VERSION_NUMBER = 8'h3c;
    // Memory type codes
    localparam logic [1:0] MEM_FPM = 2'h0;
    localparam logic [1:0] MEM_EDO = 2'h1;
    // Timing template codes
    localparam logic [2:0] TPL_STD = 3'h4;
    localparam logic [2:0] TPL_SLOW = 3'h5;
    // Template figures in half clocks
    localparam logic [2:0] HC_CAS_TO_RAS = 3'h1;
    localparam logic [2:0] HC_STD_PRECHARGE = 3'h3;
    localparam logic [2:0] HC_STD_RAS_TO_CAS = 3'h3;
    localparam logic [2:0] HC_SLOW_PRECHARGE = 3'h4;
    localparam logic [2:0] HC_SLOW_RAS_TO_CAS = 3'h4;
    // Column pulse in quarter clocks
    localparam logic [1:0] QC_CAS_SHORT = 2'h2;
    localparam logic [1:0] QC_CAS_LONG = 2'h3;
    // EDO read-to-write gap in clocks
    localparam logic [1:0] CK_GAP_SHORT = 2'h1;
    localparam logic [1:0] CK_GAP_LONG = 2'h2;
    localparam logic [1:0] CK_GAP_NONE = 2'h0;
    // Field positions
    localparam int MT_HI = 7;
    localparam int MT_LO = 6;
    localparam int TP_HI = 5;
    localparam int TP_LO = 3;
    localparam int CAS_BIT = 2;
    localparam int GAP_BIT = 1;
    localparam int RSR_BIT = 0;
    localparam int DW_HI = 7;
    localparam int DW_LO = 6;
    localparam int DR_HI = 5;
    localparam int DR_LO = 4;
    localparam int DX_HI = 3;
    localparam int TV_EN_BIT = 7;
    localparam int TV_656_BIT = 6;
    localparam int TV_GFX_BIT = 5;
    localparam int TV_BT_BIT = 4;
    localparam int TV_HS_BIT = 3;
    localparam int FF_LUMA_BIT = 2;
    localparam int FF_HI = 1;

    // Host access to index and data ports
    typedef struct packed {
        logic wr;
        logic rd;
        logic sel_data;
        logic [7:0] wdata;
    } dxr_host_t;

    // Decoded memory timing
    typedef struct packed {
        logic [1:0] mem_type;
        logic [2:0] cas_to_ras_half;
        logic [2:0] precharge_half;
        logic [2:0] ras_to_cas_half;
        logic [1:0] cas_pulse_quarter;
        logic [1:0] rd_wr_gap_clks;
        logic row_strobe_release;
    } dxr_dram_t;

    // TV interface controls
    typedef struct packed {
        logic enable;
        logic ccir656;
        logic graphics_sel;
        logic [1:0] filter_kernel;
        logic luma_only;
    } dxr_tv_t;
endpackage

// *** dxr_testbench.sv ***
`timescale 1ns/10ps
module testbench;
    import dxr_pkg::*;
    logic clk; // 250 MHz core clock
    logic nrst; // Sync reset, active low
    dxr_host_t host; // Index/data port strobes
    logic [7:0] host_rdata;
    logic host_rvalid;
    logic [15:0] frame_y_offset;
    logic [7:0] dram_arbitration_0, dram_arbitration_1; // Reserved bytes as seen by arbiter
    logic [7:0] h_char_count;
    logic odd_frame, interlace_enabled, vtiming_advance;
    dxr_dram_t dram;
    logic [1:0] ddc_in, ddc_out, ddc_oe; // Pins idle pulled high
    dxr_tv_t tv;
    logic vip_bt_dir, vip_hs_dir, tvo_bt, tvo_hs, vip_bt, vip_hs, bt_in, hs_in;
    logic bt_out, bt_oe, hs_out, hs_oe, bt_level, hs_level;
    int miscompares = 0;
    int checks_done = 0;

    dxr_regs dut_u (.clk(clk), .nrst(nrst), .host(host), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .frame_y_offset(frame_y_offset),
        .h_char_count(h_char_count), .odd_frame(odd_frame),
        .interlace_enabled(interlace_enabled), .vtiming_advance(vtiming_advance),
        .dram(dram), .dram_arbitration_0(dram_arbitration_0),
        .dram_arbitration_1(dram_arbitration_1), .ddc_in(ddc_in),
        .ddc_out(ddc_out), .ddc_oe(ddc_oe), .tv(tv), .vip_bt_dir(vip_bt_dir),
        .vip_hs_dir(vip_hs_dir), .tvo_bt(tvo_bt), .tvo_hs(tvo_hs), .vip_bt(vip_bt),
        .vip_hs(vip_hs), .bt_in(bt_in), .hs_in(hs_in), .bt_out(bt_out), .bt_oe(bt_oe),
        .hs_out(hs_out), .hs_oe(hs_oe), .bt_level(bt_level), .hs_level(hs_level));

    // Free-running clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Prints the counts and the verdict, then ends the run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Compare with case equality so an unknown matches only an unknown
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One write strobe on index (sel 0) or data (sel 1) port
    task automatic wr_port(input logic sel, input logic [7:0] d);
        @(negedge clk);
        host.wr = 1'b1;
        host.sel_data = sel;
        host.wdata = d;
        @(negedge clk);
        host.wr = 1'b0;
    endtask

    // Select by index, then write the data byte
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        wr_port(1'b0, idx);
        wr_port(1'b1, d);
    endtask

    // Select by index, read data port, bounded wait for the answer
    task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
        int n;
        wr_port(1'b0, idx);
        @(negedge clk);
        host.rd = 1'b1;
        host.sel_data = 1'b1;
        @(negedge clk);
        host.rd = 1'b0;
        n = 0;
        while (host_rvalid !== 1'b1 && n < 3) begin
            @(negedge clk);
            n++;
        end
        chk({16'h0, host_rvalid}, 17'h1);
        chk({9'h0, host_rdata}, {9'h0, exp});
    endtask

    // Let registered decode and pin synchronisers settle
    task automatic settle();
        repeat (6) @(negedge clk);
    endtask

    // Hang guard, far beyond the length of the sequence
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        host = '0;
        nrst = 1'b0;
        h_char_count = 8'h00;
        odd_frame = 1'b0;
        ddc_in = 2'b11;
        {vip_bt_dir, vip_hs_dir, vip_bt, vip_hs} = 4'h0;
        {tvo_bt, tvo_hs, bt_in, hs_in} = 4'hc;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        settle();
        // Reset values and decoded defaults
        reg_rd(IDX_INTERLACE_HALF_FIELD_START, 8'hff);
        chk({16'h0, interlace_enabled}, 17'h0);
        reg_rd(IDX_DRAM_TIMING_PARAMETERS, 8'h00);
        reg_rd(IDX_MONITOR_DATA_CHANNEL_CTRL, 8'hff);
        chk({15'h0, ddc_oe}, 17'h0);
        // Implementation number ignores a write; both identification bytes read
        reg_wr(IDX_IMPLEMENTATION_NUMBER, 8'h00);
        reg_rd(IDX_IMPLEMENTATION_NUMBER, IMPL_NUMBER);
        reg_rd(IDX_GRAPHICS_VERSION_NUMBER, VERSION_NUMBER);
        // Unmapped index reads zero; index port reads back
        reg_wr(8'h50, 8'ha5);
        reg_rd(8'h50, 8'h00);
        // Read on the index port itself
        @(negedge clk);
        host.rd = 1'b1;
        host.sel_data = 1'b0;
        @(negedge clk);
        host.rd = 1'b0;
        chk({16'h0, host_rvalid}, 17'h1);
        chk({9'h0, host_rdata}, {9'h0, 8'h50});
        reg_wr(IDX_DRAM_ARBITRATION_CTRL_1, 8'h00);
        reg_rd(IDX_DRAM_ARBITRATION_CTRL_1, 8'h00);
        chk({1'b0, dram_arbitration_0, dram_arbitration_1}, 17'h0);
        // Negative offset exercises the sign byte
        reg_wr(IDX_FRAME_Y_OFFSET_LOW, 8'h80);
        reg_wr(IDX_FRAME_Y_OFFSET_HIGH, 8'hff);
        settle();
        chk({1'b0, frame_y_offset}, {1'b0, 16'hff80});
        // FPM, standard template, long pulse, row released
        reg_wr(IDX_DRAM_TIMING_PARAMETERS, 8'h25);
        settle();
        chk(dram, {MEM_FPM, HC_CAS_TO_RAS, HC_STD_PRECHARGE, HC_STD_RAS_TO_CAS,
            QC_CAS_LONG, CK_GAP_NONE, 1'b1});
        // EDO, slow template, long gap, row kept
        reg_wr(IDX_DRAM_TIMING_PARAMETERS, 8'h6a);
        settle();
        chk(dram, {MEM_EDO, HC_CAS_TO_RAS, HC_SLOW_PRECHARGE, HC_SLOW_RAS_TO_CAS,
            QC_CAS_SHORT, CK_GAP_LONG, 1'b0});
        // Pin 0 pulled low by us, pin 1 held low by another master
        ddc_in = 2'b00;
        reg_wr(IDX_MONITOR_DATA_CHANNEL_CTRL, 8'hbf);
        settle();
        chk({13'h0, ddc_oe, ddc_out}, {13'h0, 2'b01, 2'b00});
        reg_rd(IDX_MONITOR_DATA_CHANNEL_CTRL, 8'h8f);
        reg_wr(IDX_MONITOR_DATA_CHANNEL_CTRL, 8'hff);
        ddc_in = 2'b11;
        settle();
        chk({15'h0, ddc_oe}, 17'h0);
        reg_rd(IDX_MONITOR_DATA_CHANNEL_CTRL, 8'hff);
        // Interlace match only on odd frames
        reg_wr(IDX_INTERLACE_HALF_FIELD_START, 8'h20);
        settle();
        chk({16'h0, interlace_enabled}, 17'h1);
        h_char_count = 8'h20;
        @(negedge clk);
        h_char_count = 8'h21;
        chk({16'h0, vtiming_advance}, 17'h0);
        @(negedge clk);
        odd_frame = 1'b1;
        h_char_count = 8'h20;
        @(negedge clk);
        h_char_count = 8'h21;
        chk({16'h0, vtiming_advance}, 17'h1);
        @(negedge clk);
        chk({16'h0, vtiming_advance}, 17'h0);
        // Back to all ones: no advance even at a match
        reg_wr(IDX_INTERLACE_HALF_FIELD_START, 8'hff);
        h_char_count = 8'hff;
        @(negedge clk);
        chk({15'h0, interlace_enabled, vtiming_advance}, 17'h0);
        // TV control decode over every kernel
        reg_wr(IDX_TV_INTERFACE_CTRL, 8'hff);
        settle();
        chk({11'h0, tv}, {11'h0, 6'b111111});
        reg_wr(IDX_TV_INTERFACE_CTRL, 8'h46);
        settle();
        chk({11'h0, tv}, {11'h0, 6'b010101});
        reg_wr(IDX_TV_INTERFACE_CTRL, 8'h21);
        settle();
        chk({11'h0, tv}, {11'h0, 6'b001010});
        reg_wr(IDX_TV_INTERFACE_CTRL, 8'h04);
        settle();
        chk({11'h0, tv}, {11'h0, 6'b000000});
        // Pin direction: TV generator, video input, then input only
        {bt_in, hs_in} = 2'b11;
        reg_wr(IDX_TV_INTERFACE_CTRL, 8'h18);
        settle();
        chk({13'h0, bt_oe, bt_out, hs_oe, hs_out}, 17'hf);
        chk({15'h0, bt_level, hs_level}, 17'h3);
        vip_bt_dir = 1'b1;
        vip_hs_dir = 1'b1;
        {bt_in, hs_in} = 2'b00;
        reg_wr(IDX_TV_INTERFACE_CTRL, 8'h00);
        settle();
        chk({13'h0, bt_oe, bt_out, hs_oe, hs_out}, 17'ha);
        vip_bt_dir = 1'b0;
        vip_hs_dir = 1'b0;
        {bt_in, hs_in} = 2'b10;
        settle();
        chk({15'h0, bt_oe, hs_oe}, 17'h0);
        chk({15'h0, bt_level, hs_level}, 17'h2);
        report_and_stop();
    end
endmodule
